// ---- pkg/pifen_pkg.sv ----
// Constants for the peripheral interrupt flag and enable block.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
package pifen_pkg;

  localparam int PIFEN_ADR_W = 8;
  localparam int PIFEN_DAT_W = 32;
  localparam int PIFEN_REG_W = 8;

  // Byte offsets of the word registers.
  localparam logic [7:0] PIFEN_OFS_PWM_EN = 8'h00;
  localparam logic [7:0] PIFEN_OFS_FLAGS1 = 8'h04;
  localparam logic [7:0] PIFEN_OFS_FLAGS1_EN = 8'h08;
  localparam logic [7:0] PIFEN_OFS_CTRL = 8'h0C;
  localparam logic [7:0] PIFEN_OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] PIFEN_OFS_IRQ_MASK = 8'h14;

  // pwm_interrupt_enable layout: units one to three sit at bits 4 to 6.
  localparam int PIFEN_PWM_UNITS = 3;
  localparam int PIFEN_PWM_EN_LSB = 4;
  localparam logic [7:0] PIFEN_PWM_EN_IMPL = 8'h70;

  // peripheral_request_flags_one layout.
  localparam int PIFEN_BIT_TIMER_GATE = 7;
  localparam int PIFEN_BIT_CONV_DONE = 6;
  localparam int PIFEN_BIT_SER_RX = 5;
  localparam int PIFEN_BIT_SER_TX = 4;
  localparam int PIFEN_BIT_PERIOD_MATCH = 1;
  localparam int PIFEN_BIT_OVERFLOW = 0;
  localparam logic [7:0] PIFEN_FLAGS1_IMPL = 8'hF3;
  localparam logic [7:0] PIFEN_FLAGS1_WR = 8'hD3;
  localparam logic [7:0] PIFEN_FLAGS1_LEVEL = 8'h20;

  // Control register: bit 0 is the peripheral interrupt enable.
  localparam int PIFEN_BIT_PERIPH_EN = 0;

  // Interrupt status and mask: bits 0 to 2 PWM requests, bit 3 flag request.
  localparam int PIFEN_IRQ_W = 4;
  localparam int PIFEN_IRQ_FLAGS_BIT = 3;
  localparam logic [7:0] PIFEN_IRQ_IMPL = 8'h0F;

  localparam logic [7:0] PIFEN_RST_BYTE = 8'h00;
  localparam logic [31:0] PIFEN_RST_WORD = 32'h0000_0000;

endpackage

// ---- core/pifen_flag_cell.sv ----
// Bank of flag bits that hardware sets and software writes or clears.
// Assumes set inputs and writes are synchronous to i_clock.
`timescale 1ns/10ps
`default_nettype none

module pifen_flag_cell #(
  parameter int W = 8,
  parameter logic [W-1:0] IMPL = '1,
  parameter logic [W-1:0] WR_MASK = '1,
  parameter logic [W-1:0] LEVEL_MASK = '0,
  parameter bit W1C = 1'b0
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_set,
  input wire logic i_wr,
  input wire logic [W-1:0] i_wdata,
  output logic [W-1:0] o_flags
);

  typedef struct packed {
    logic [W-1:0] flags;
  } pifen_cell_t;

  pifen_cell_t q, d;
  logic [W-1:0] kept;

  always_comb begin
    kept = q.flags;
    if (i_wr) begin
      if (W1C) begin
        kept = q.flags & ~i_wdata;
      end else begin
        kept = (q.flags & ~WR_MASK) | (i_wdata & WR_MASK);
      end
    end
    // A set that lands on the clearing write wins, so no event is lost.
    d.flags = ((kept | i_set) & ~LEVEL_MASK) | (i_set & LEVEL_MASK);
    d.flags = d.flags & IMPL;
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_flags = q.flags;

  a_set_wins: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (i_set & IMPL & ~LEVEL_MASK) != '0 |=> (o_flags & $past(i_set & IMPL)) == $past(i_set & IMPL))
    else $error("Flag set was lost.");
  a_unimpl_low: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (o_flags & ~IMPL) == '0)
    else $error("Unimplemented flag bit is set.");

endmodule

`default_nettype wire

// ---- core/pifen_top.sv ----
// Peripheral interrupt enable and flag registers with a Wishbone slave.
// Assumes classic Wishbone single cycles and event inputs synchronous to i_clock.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Third PWM unit request passes only while its enable bit is one.
// - Second PWM unit request passes only while its enable bit is one.
// - First PWM unit request passes only while its enable bit is one.
// - Unimplemented bit positions read zero and ignore writes.
// - Every implemented bit is zero after any reset.
// - A flag reads one while pending and zero otherwise.
// - Bit 7 holds the timer gate flag, readable and writable.
// - Bit 6 holds the conversion done flag, readable and writable.
// - Bit 5 holds the serial receive flag, read only.
// - Bit 4 holds the serial transmit flag, transmitter ready for data.
// - Bit 1 sets on timer period match, readable and writable.
// - Bit 0 sets on timer overflow, readable and writable.
// - Flags set on their event regardless of any enable.
module pifen_top
  import pifen_pkg::*;
#(
  parameter int PWM_UNITS = PIFEN_PWM_UNITS
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [PIFEN_ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [PIFEN_DAT_W-1:0] i_wb_dat,
  output logic o_wb_ack,
  output logic [PIFEN_DAT_W-1:0] o_wb_dat,
  input wire logic [PWM_UNITS-1:0] i_pwm_flag,
  input wire logic i_evt_timer_gate,
  input wire logic i_evt_conv_done,
  input wire logic i_rx_pending,
  input wire logic i_evt_tx_ready,
  input wire logic i_evt_period_match,
  input wire logic i_evt_overflow,
  output logic [PWM_UNITS-1:0] o_pwm_req,
  output logic o_flags_req,
  output logic o_periph_req,
  output logic o_irq
);

  typedef struct packed {
    logic [PWM_UNITS-1:0] pwm_en;
    logic [PIFEN_REG_W-1:0] flags_en;
    logic periph_en;
    logic [PIFEN_IRQ_W-1:0] irq_mask;
    logic ack;
    logic [PIFEN_DAT_W-1:0] rdat;
    logic [PWM_UNITS-1:0] pwm_req;
    logic flags_req;
    logic periph_req;
    logic irq;
  } pifen_state_t;

  pifen_state_t q, d;

  logic [PIFEN_REG_W-1:0] flags1;
  logic [PIFEN_REG_W-1:0] flags1_set;
  logic [PIFEN_REG_W-1:0] irq_status;
  logic [PIFEN_REG_W-1:0] irq_set;
  logic access;
  logic wr_lane;
  logic wr_flags1;
  logic wr_status;
  logic [PWM_UNITS-1:0] pwm_now;
  logic flags_now;

  // Low byte of the write data, kept only where the mask has bits.
  function automatic logic [PIFEN_REG_W-1:0] lane_bits(
    input logic [PIFEN_DAT_W-1:0] data,
    input logic [PIFEN_REG_W-1:0] mask
  );
    lane_bits = data[PIFEN_REG_W-1:0] & mask;
  endfunction

  // Zero-extends a register byte onto the bus word.
  function automatic logic [PIFEN_DAT_W-1:0] to_word(input logic [PIFEN_REG_W-1:0] b);
    to_word = {{(PIFEN_DAT_W-PIFEN_REG_W){1'b0}}, b};
  endfunction

  // Flags are set by their sources whatever the enables say.
  always_comb begin
    flags1_set = PIFEN_RST_BYTE;
    flags1_set[PIFEN_BIT_TIMER_GATE] = i_evt_timer_gate;
    flags1_set[PIFEN_BIT_CONV_DONE] = i_evt_conv_done;
    flags1_set[PIFEN_BIT_SER_RX] = i_rx_pending;
    flags1_set[PIFEN_BIT_SER_TX] = i_evt_tx_ready;
    flags1_set[PIFEN_BIT_PERIOD_MATCH] = i_evt_period_match;
    flags1_set[PIFEN_BIT_OVERFLOW] = i_evt_overflow;
  end

  // The receive flag is read only and mirrors the receiver, so software cannot
  // drop a byte by clearing it.
  pifen_flag_cell #(
    .W(PIFEN_REG_W),
    .IMPL(PIFEN_FLAGS1_IMPL),
    .WR_MASK(PIFEN_FLAGS1_WR),
    .LEVEL_MASK(PIFEN_FLAGS1_LEVEL),
    .W1C(1'b0)
  ) u_flags1 (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_set(flags1_set),
    .i_wr(wr_flags1),
    .i_wdata(lane_bits(i_wb_dat, PIFEN_FLAGS1_WR)),
    .o_flags(flags1)
  );

  pifen_flag_cell #(
    .W(PIFEN_REG_W),
    .IMPL(PIFEN_IRQ_IMPL),
    .WR_MASK(PIFEN_IRQ_IMPL),
    .LEVEL_MASK(PIFEN_RST_BYTE),
    .W1C(1'b1)
  ) u_irq_status (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_set(irq_set),
    .i_wr(wr_status),
    .i_wdata(lane_bits(i_wb_dat, PIFEN_IRQ_IMPL)),
    .o_flags(irq_status)
  );

  always_comb begin
    access = i_wb_cyc && i_wb_stb && !q.ack;
    wr_lane = access && i_wb_we && i_wb_sel[0];
    wr_flags1 = wr_lane && (i_wb_adr == PIFEN_OFS_FLAGS1);
    wr_status = wr_lane && (i_wb_adr == PIFEN_OFS_IRQ_STATUS);
    pwm_now = i_pwm_flag & q.pwm_en & {PWM_UNITS{q.periph_en}};
    flags_now = (|(flags1 & q.flags_en)) && q.periph_en;
    irq_set = PIFEN_RST_BYTE;
    irq_set[PWM_UNITS-1:0] = pwm_now & ~q.pwm_req;
    irq_set[PIFEN_IRQ_FLAGS_BIT] = flags_now && !q.flags_req;
  end

  always_comb begin
    d = q;
    d.ack = access;
    // Writes land on the edge that raises ack, one cycle after the request.
    if (wr_lane) begin
      unique case (i_wb_adr)
        PIFEN_OFS_PWM_EN: begin
          d.pwm_en = i_wb_dat[PIFEN_PWM_EN_LSB +: PWM_UNITS];
        end
        PIFEN_OFS_FLAGS1_EN: begin
          d.flags_en = lane_bits(i_wb_dat, PIFEN_FLAGS1_IMPL);
        end
        PIFEN_OFS_CTRL: begin
          d.periph_en = i_wb_dat[PIFEN_BIT_PERIPH_EN];
        end
        PIFEN_OFS_IRQ_MASK: begin
          d.irq_mask = i_wb_dat[PIFEN_IRQ_W-1:0];
        end
        default: begin
          d.periph_en = q.periph_en;
        end
      endcase
    end
    d.rdat = PIFEN_RST_WORD;
    if (access && !i_wb_we) begin
      unique case (i_wb_adr)
        PIFEN_OFS_PWM_EN: begin
          d.rdat[PIFEN_PWM_EN_LSB +: PWM_UNITS] = q.pwm_en;
        end
        PIFEN_OFS_FLAGS1: begin
          d.rdat = to_word(flags1);
        end
        PIFEN_OFS_FLAGS1_EN: begin
          d.rdat = to_word(q.flags_en);
        end
        PIFEN_OFS_CTRL: begin
          d.rdat[PIFEN_BIT_PERIPH_EN] = q.periph_en;
        end
        PIFEN_OFS_IRQ_STATUS: begin
          d.rdat = to_word(irq_status);
        end
        PIFEN_OFS_IRQ_MASK: begin
          d.rdat[PIFEN_IRQ_W-1:0] = q.irq_mask;
        end
        default: begin
          d.rdat = PIFEN_RST_WORD;
        end
      endcase
    end
    d.pwm_req = pwm_now;
    d.flags_req = flags_now;
    d.periph_req = (|pwm_now) || flags_now;
    d.irq = |(irq_status[PIFEN_IRQ_W-1:0] & q.irq_mask);
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_wb_ack = q.ack;
  assign o_wb_dat = q.rdat;
  assign o_pwm_req = q.pwm_req;
  assign o_flags_req = q.flags_req;
  assign o_periph_req = q.periph_req;
  assign o_irq = q.irq;

  // Helper terms for the checks below.
  logic read_flags1;
  logic wr_pwm_en;
  logic read_pwm_en;
  assign read_flags1 = access && !i_wb_we && (i_wb_adr == PIFEN_OFS_FLAGS1);
  assign wr_pwm_en = wr_lane && (i_wb_adr == PIFEN_OFS_PWM_EN);
  assign read_pwm_en = access && !i_wb_we && (i_wb_adr == PIFEN_OFS_PWM_EN);

  a_pwm3_gate: assert property (@(posedge i_clock) disable iff (!i_rstn)
    o_pwm_req[2] |-> $past(i_pwm_flag[2] && q.pwm_en[2] && q.periph_en))
    else $error("Third PWM request without flag and enables.");

  a_pwm3_pass: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (i_pwm_flag[2] && q.pwm_en[2] && q.periph_en) |=> o_pwm_req[2])
    else $error("Third PWM request blocked while enabled.");

  a_pwm2_gate: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (i_pwm_flag[1] && !q.pwm_en[1]) |=> !o_pwm_req[1])
    else $error("Second PWM request passed while disabled.");

  a_pwm1_enable: assert property (@(posedge i_clock) disable iff (!i_rstn)
    wr_pwm_en |=> q.pwm_en[0] == $past(i_wb_dat[PIFEN_PWM_EN_LSB]))
    else $error("First PWM enable did not take the written value.");

  a_pwm_pass: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (i_pwm_flag[0] && q.pwm_en[0] && q.periph_en) |=> o_pwm_req[0])
    else $error("First PWM request blocked while enabled.");

  a_unused_zero: assert property (@(posedge i_clock) disable iff (!i_rstn)
    o_wb_ack |-> o_wb_dat[PIFEN_DAT_W-1:PIFEN_REG_W] == '0)
    else $error("Unimplemented read bits are not zero.");

  a_pwm_read_zero: assert property (@(posedge i_clock) disable iff (!i_rstn)
    read_pwm_en |=> (o_wb_dat & ~to_word(PIFEN_PWM_EN_IMPL)) == '0)
    else $error("Unused enable bits read as one.");

  a_reset_clear: assert property (@(posedge i_clock)
    !i_rstn |-> (q.pwm_en == '0 && flags1 == PIFEN_RST_BYTE && !o_irq))
    else $error("State not clear during reset.");

  a_flag_read: assert property (@(posedge i_clock) disable iff (!i_rstn)
    read_flags1 |=> o_wb_ack && o_wb_dat == to_word($past(flags1)))
    else $error("Flag read does not show pending flags.");

  a_conv_quiet: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (!flags1[PIFEN_BIT_CONV_DONE] && !i_evt_conv_done && !wr_flags1) |=>
      !flags1[PIFEN_BIT_CONV_DONE])
    else $error("Conversion flag rose with no event.");

  a_gate_write: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (wr_flags1 && !i_evt_timer_gate) |=>
      flags1[PIFEN_BIT_TIMER_GATE] == $past(i_wb_dat[PIFEN_BIT_TIMER_GATE]))
    else $error("Timer gate flag ignored a write.");

  a_gate_no_enable: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (i_evt_timer_gate && !q.periph_en) |=> flags1[PIFEN_BIT_TIMER_GATE])
    else $error("Timer gate flag waited for an enable.");

  a_conv_set: assert property (@(posedge i_clock) disable iff (!i_rstn)
    i_evt_conv_done |=> flags1[PIFEN_BIT_CONV_DONE])
    else $error("Conversion flag missed its event.");

  a_rx_mirror: assert property (@(posedge i_clock) disable iff (!i_rstn)
    ##1 flags1[PIFEN_BIT_SER_RX] == $past(i_rx_pending))
    else $error("Receive flag does not follow the receiver.");

  a_rx_readonly: assert property (@(posedge i_clock) disable iff (!i_rstn)
    wr_flags1 |=> flags1[PIFEN_BIT_SER_RX] == $past(i_rx_pending))
    else $error("Software write altered the receive flag.");

  a_tx_set: assert property (@(posedge i_clock) disable iff (!i_rstn)
    i_evt_tx_ready |=> flags1[PIFEN_BIT_SER_TX])
    else $error("Transmit flag missed its event.");

  a_period_set: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (i_evt_period_match && !q.periph_en) |=> flags1[PIFEN_BIT_PERIOD_MATCH])
    else $error("Period match flag missed its event.");

  a_overflow_hold: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (flags1[PIFEN_BIT_OVERFLOW] && !wr_flags1) |=> flags1[PIFEN_BIT_OVERFLOW])
    else $error("Overflow flag dropped without a write.");

  a_periph_req: assert property (@(posedge i_clock) disable iff (!i_rstn)
    o_periph_req |-> $past(q.periph_en) && (o_flags_req || (|o_pwm_req)))
    else $error("Core request without peripheral enable.");

  a_flags_gate: assert property (@(posedge i_clock) disable iff (!i_rstn)
    o_flags_req |-> $past(q.periph_en && ((flags1 & q.flags_en) != '0)))
    else $error("Flag request without an enabled pending flag.");

  // Status latches only the rising request, so a held request cannot retrigger after a clear.
  a_pwm_irq_set: assert property (@(posedge i_clock) disable iff (!i_rstn)
    $rose(o_pwm_req[0]) |-> irq_status[0])
    else $error("Rising PWM request did not set its status bit.");

  a_status_w1c: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (wr_status && i_wb_dat[PIFEN_IRQ_FLAGS_BIT] && !irq_set[PIFEN_IRQ_FLAGS_BIT]) |=>
      !irq_status[PIFEN_IRQ_FLAGS_BIT])
    else $error("Writing one did not clear the status bit.");

  a_irq_high: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (irq_status[PIFEN_IRQ_W-1:0] & q.irq_mask) != '0 |=> o_irq)
    else $error("Interrupt low while an unmasked status bit is set.");

  a_irq_level: assert property (@(posedge i_clock) disable iff (!i_rstn)
    ##1 o_irq == $past(|(irq_status[PIFEN_IRQ_W-1:0] & q.irq_mask)))
    else $error("Interrupt output does not track masked status.");

  a_ack_pulse: assert property (@(posedge i_clock) disable iff (!i_rstn)
    o_wb_ack |=> !o_wb_ack)
    else $error("Acknowledge held longer than one cycle.");

  a_ack_answer: assert property (@(posedge i_clock) disable iff (!i_rstn)
    access |=> o_wb_ack)
    else $error("Taken request was not acknowledged in the next cycle.");

  // Read data is held at zero outside an acknowledge, so an OR of slave buses stays clean.
  a_dat_idle: assert property (@(posedge i_clock) disable iff (!i_rstn)
    !o_wb_ack |-> o_wb_dat == '0)
    else $error("Read data not zero outside an acknowledge.");

  c_flag_write: cover property (@(posedge i_clock) disable iff (!i_rstn)
    wr_flags1 ##1 o_wb_ack);
  c_pwm_request: cover property (@(posedge i_clock) disable iff (!i_rstn)
    $rose(o_pwm_req[0]) ##[1:4] o_irq);
  c_set_on_clear: cover property (@(posedge i_clock) disable iff (!i_rstn)
    wr_flags1 && i_evt_overflow);
  c_status_clear: cover property (@(posedge i_clock) disable iff (!i_rstn)
    o_irq && wr_status ##2 !o_irq);
  c_rx_read: cover property (@(posedge i_clock) disable iff (!i_rstn)
    $rose(flags1[PIFEN_BIT_SER_RX]) ##[1:20] read_flags1);

endmodule

`default_nettype wire

// ---- tb/pifen_evt_model.sv ----
// Model of the peripheral event sources beside the flag block.
// Assumes the bench gives one command bit per source on i_cmd.
`timescale 1ns/10ps
`default_nettype none
module pifen_evt_model (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic [8:0] i_cmd,
  output logic [8:0] o_evt
);
  // Sources answer one clock after a command, like a registered peripheral strobe.
  // Bits 2:0 and 5 are levels; the bench holds them, the rest are pulses.
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_evt <= 9'h000;
    end else begin
      o_evt <= i_cmd;
    end
  end
endmodule
`default_nettype wire

// ---- tb/pifen_top_tb.sv ----
// Self-checking bench for the peripheral interrupt flag and enable block.
// Assumes the event model drives all event inputs from the bench's commands.
`timescale 1ns/10ps
`default_nettype none
module pifen_top_tb;
  import pifen_pkg::*;
  logic i_clock, i_rstn, cyc, stb, we, ack, flags_req, periph_req, irq;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, rd;
  logic [8:0] cmd, evt;
  logic [2:0] pwm_req;
  logic [7:0] fbit [6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h02, 8'h01};
  int errors, total_checks;

  pifen_top uut (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat),
    .o_wb_ack(ack), .o_wb_dat(rdat), .i_pwm_flag(evt[2:0]),
    .i_evt_timer_gate(evt[3]), .i_evt_conv_done(evt[4]), .i_rx_pending(evt[5]),
    .i_evt_tx_ready(evt[6]), .i_evt_period_match(evt[7]), .i_evt_overflow(evt[8]),
    .o_pwm_req(pwm_req), .o_flags_req(flags_req), .o_periph_req(periph_req),
    .o_irq(irq)
  );

  pifen_evt_model src (.i_clock(i_clock), .i_rstn(i_rstn), .i_cmd(cmd), .o_evt(evt));

  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Entered just after a rising edge; ack is read before that edge's updates land.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge i_clock);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      $display("[FAIL] bus ack expected 1 seen none");
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge i_clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, {24'h000000, d});
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    wb(1'b0, a, 32'h00000000);
    chk(nm, {24'h000000, e}, rd);
  endtask

  // Level sources (PWM units, receiver) stay up until the next command.
  task automatic fire(input logic [8:0] c);
    cmd <= c;
    @(posedge i_clock);
    cmd <= c & 9'h027;
    repeat (6) @(posedge i_clock);
  endtask

  initial begin
    #2000000;
    errors++;
    report_and_stop();
  end

  initial begin
    i_rstn = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    wdat = 32'h00000000;
    cmd = 9'h000;
    errors = 0;
    total_checks = 0;
    repeat (20) @(posedge i_clock);
    i_rstn <= 1'b1;
    @(posedge i_clock);
    for (int a = 0; a < 24; a += 4) rchk("reset value", 8'(a), 8'h00);
    $display("test reset done");
    wr(PIFEN_OFS_PWM_EN, 8'hFF);
    rchk("enable reserved", PIFEN_OFS_PWM_EN, 8'h70);
    wr(8'h20, 8'hFF);
    rchk("unmapped", 8'h20, 8'h00);
    wr(PIFEN_OFS_PWM_EN, 8'h00);
    $display("test reserved done");
    for (int i = 3; i < 9; i++) begin
      fire(9'h001 << i);
      rchk("flag set", PIFEN_OFS_FLAGS1, fbit[i-3]);
      wr(PIFEN_OFS_FLAGS1, 8'h00);
      rchk("flag clear", PIFEN_OFS_FLAGS1, (i == 5) ? 8'h20 : 8'h00);
      fire(9'h000);
    end
    rchk("flags idle", PIFEN_OFS_FLAGS1, 8'h00);
    wr(PIFEN_OFS_FLAGS1, 8'hFF);
    rchk("flags written", PIFEN_OFS_FLAGS1, 8'hD3);
    wr(PIFEN_OFS_FLAGS1, 8'h00);
    $display("test flags done");
    wr(PIFEN_OFS_CTRL, 8'h01);
    fire(9'h007);
    for (int u = 0; u < 3; u++) begin
      wr(PIFEN_OFS_PWM_EN, 8'h10 << u);
      repeat (3) @(posedge i_clock);
      chk("pwm request", 32'(1 << u), {29'h0, pwm_req});
      chk("periph request", 32'h1, {31'h0, periph_req});
    end
    wr(PIFEN_OFS_CTRL, 8'h00);
    repeat (3) @(posedge i_clock);
    chk("pwm gated", 32'h0, {29'h0, pwm_req});
    wr(PIFEN_OFS_PWM_EN, 8'h00);
    fire(9'h000);
    $display("test pwm done");
    wr(PIFEN_OFS_FLAGS1, 8'h00);
    wr(PIFEN_OFS_IRQ_STATUS, 8'h0F);
    wr(PIFEN_OFS_FLAGS1_EN, 8'h01);
    wr(PIFEN_OFS_CTRL, 8'h01);
    wr(PIFEN_OFS_IRQ_MASK, 8'h08);
    fire(9'h100);
    chk("flags request", 32'h1, {31'h0, flags_req});
    chk("irq raised", 32'h1, {31'h0, irq});
    rchk("irq status", PIFEN_OFS_IRQ_STATUS, 8'h08);
    wr(PIFEN_OFS_FLAGS1, 8'h00);
    wr(PIFEN_OFS_IRQ_STATUS, 8'h08);
    repeat (2) @(posedge i_clock);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(PIFEN_OFS_IRQ_MASK, 8'h00);
    fire(9'h100);
    chk("irq masked", 32'h0, {31'h0, irq});
    rchk("masked status", PIFEN_OFS_IRQ_STATUS, 8'h08);
    $display("test irq done");
    wr(PIFEN_OFS_PWM_EN, 8'h70);
    wr(PIFEN_OFS_IRQ_MASK, 8'h0F);
    i_rstn <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_rstn <= 1'b1;
    @(posedge i_clock);
    for (int a = 0; a < 24; a += 4) rchk("reset again", 8'(a), 8'h00);
    chk("irq after reset", 32'h0, {31'h0, irq});
    chk("request after reset", 32'h0, {31'h0, periph_req});
    $display("test mid reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
